// File: hw/lc_pkg.sv
package lc_pkg;

	// Clock rate and the cycle count of one millisecond tick.
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned CYC_PER_MS_DEF  = CLK_HZ / MS_PER_S;

	// Test input timing, all in milliseconds.
	localparam int unsigned RESP_MS_DEF     = 20;
	localparam int unsigned T1_EXTRA_MS     = 15;
	localparam int unsigned RESTART_MAX_MS  = 800;
	localparam int unsigned SETTLE_MS_DEF   = 100;

	// Power-up self-test duration with a clear field, in milliseconds.
	localparam int unsigned STARTUP_MS_DEF  = 2000;

	// Indicator timing, in milliseconds.
	localparam int unsigned FLASH_MS        = 250;
	localparam int unsigned PULSE_PERIOD_MS = 3000;
	localparam int unsigned PULSE_LEN_MS    = 100;

	// Output readback mismatch filter, in clock cycles.
	localparam int unsigned SC_FILT_CYC_DEF = 16;

	// Width of the millisecond timers and of the readback mismatch cycle counter.
	localparam int unsigned TMR_W           = 12;
	localparam int unsigned MM_W            = 8;

	// Pattern for the irregular flash of an internal controller fault.
	localparam logic [7:0]  IRREG_PAT       = 8'hB2;

	// Input vector layout through the synchroniser.
	localparam int unsigned IN_W            = 9;
	localparam int unsigned IX_TEST         = 0;
	localparam int unsigned IX_CLEAR        = 1;
	localparam int unsigned IX_ALIGN        = 2;
	localparam int unsigned IX_CONN         = 3;
	localparam int unsigned IX_SUPPLY       = 4;
	localparam int unsigned IX_CERR         = 5;
	localparam int unsigned IX_FERR         = 6;
	localparam int unsigned IX_RBA          = 7;
	localparam int unsigned IX_RBB          = 8;

	typedef enum logic [2:0] {
		ST_SELFTEST,
		ST_RUN,
		ST_TEST,
		ST_RESTART,
		ST_SHORT,
		ST_LOWPWR,
		ST_CTRL_ERR,
		ST_FIELD_ERR
	} state_e;

endpackage

// File: hw/sync2.sv
module sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		meta_nxt = d_i;
		q_nxt    = meta_r;
	end

	// Two stages clear metastability before any logic reads a pin.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else if (en_i) begin
			meta_r <= meta_nxt;
			q_o    <= q_nxt;
		end
	end

endmodule

// File: hw/light_curtain_ctrl.sv
// Contract
// - Emit only while test contact closed; indicate.
// - React to opened test within response+15ms.
// - Resume operation within 800 ms after test.
// - Power indication and ready only after self-test.
// - Self-test needs alignment, connection, clear field.
// - Intrusion turns outputs off, indicator to red.
// - Monitor both outputs for short circuits.
// - Transmitter indicators follow test contact state.
// - Transmitter internal error: flash, off, red.
// - Low supply: receiver power on, others off.
// - Outputs on: receiver power, green, red on.
// - Outputs off: flash power, green off, red.
// - Short: brief pulse each 3 s, red flashes.
// - Field error: flash power, green off, flash.
// - Controller error: irregular flash, red on.
// - Each detected error shows distinct indicators.
// - Clear field: working about two seconds after power.
module light_curtain_ctrl #(
	parameter int unsigned CYC_PER_MS  = lc_pkg::CYC_PER_MS_DEF,
	parameter int unsigned RESP_MS     = lc_pkg::RESP_MS_DEF,
	parameter int unsigned STARTUP_MS  = lc_pkg::STARTUP_MS_DEF,
	parameter int unsigned SETTLE_MS   = lc_pkg::SETTLE_MS_DEF,
	parameter int unsigned SC_FILT_CYC = lc_pkg::SC_FILT_CYC_DEF
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic en_i,
	input  wire logic test_closed_i,
	input  wire logic field_clear_i,
	input  wire logic aligned_i,
	input  wire logic connected_i,
	input  wire logic supply_ok_i,
	input  wire logic ctrl_fault_i,
	input  wire logic field_fault_i,
	input  wire logic readback_a_i,
	input  wire logic readback_b_i,
	output logic      safety_switch_output_a_o,
	output logic      safety_switch_output_b_o,
	output logic      tx_emit_o,
	output logic      ready_o,
	output logic      test_active_o,
	output logic      short_fault_o,
	output logic      tx_led_pwr_o,
	output logic      tx_led_grn_o,
	output logic      tx_led_red_o,
	output logic      rx_led_pwr_o,
	output logic      rx_led_grn_o,
	output logic      rx_led_red_o
);
	import lc_pkg::*;

	localparam int unsigned PRE_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);
	localparam logic [TMR_W-1:0] T1_T     = TMR_W'(RESP_MS + T1_EXTRA_MS);
	localparam logic [TMR_W-1:0] START_T  = TMR_W'(STARTUP_MS - 1);
	localparam logic [TMR_W-1:0] SETTLE_T = TMR_W'(SETTLE_MS - 1);
	localparam logic [TMR_W-1:0] FLASH_T  = TMR_W'(FLASH_MS - 1);
	localparam logic [TMR_W-1:0] PER_T    = TMR_W'(PULSE_PERIOD_MS - 1);
	localparam logic [TMR_W-1:0] PLEN_T   = TMR_W'(PULSE_LEN_MS);
	localparam logic [MM_W-1:0]  MM_LIM   = MM_W'(SC_FILT_CYC);
	localparam logic [TMR_W-1:0] TMR_ONE  = TMR_W'(1);
	localparam logic [MM_W-1:0]  MM_ONE   = MM_W'(1);

	logic [IN_W-1:0]  pins_w;
	logic [IN_W-1:0]  sync_w;
	logic             test_s;
	logic             clear_s;
	logic             align_s;
	logic             conn_s;
	logic             supply_s;
	logic             cerr_s;
	logic             ferr_s;
	logic             rba_s;
	logic             rbb_s;

	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] pre_nxt;
	logic [TMR_W-1:0] fl_r;
	logic [TMR_W-1:0] fl_nxt;
	logic [2:0]       ph_r;
	logic [2:0]       ph_nxt;
	logic [TMR_W-1:0] pt_r;
	logic [TMR_W-1:0] pt_nxt;
	logic             ms_tick;

	state_e           st_r;
	state_e           st_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic [MM_W-1:0]  mm_r;
	logic [MM_W-1:0]  mm_nxt;
	logic             self_ok;
	logic             mismatch;

	logic             run_on;
	logic             flash;
	logic             irreg;
	logic             pulse;
	logic [11:0]      out_nxt;

	// All pins come from outside the clock domain.
	assign pins_w = {readback_b_i, readback_a_i, field_fault_i, ctrl_fault_i,
		supply_ok_i, connected_i, aligned_i, field_clear_i, test_closed_i};

	sync2 #(
		.W (IN_W)
	) u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.en_i   (en_i),
		.d_i    (pins_w),
		.q_o    (sync_w)
	);

	assign test_s   = sync_w[IX_TEST];
	assign clear_s  = sync_w[IX_CLEAR];
	assign align_s  = sync_w[IX_ALIGN];
	assign conn_s   = sync_w[IX_CONN];
	assign supply_s = sync_w[IX_SUPPLY];
	assign cerr_s   = sync_w[IX_CERR];
	assign ferr_s   = sync_w[IX_FERR];
	assign rba_s    = sync_w[IX_RBA];
	assign rbb_s    = sync_w[IX_RBB];

	// Millisecond prescaler and indicator timebases.
	// Keeping the state and indicator timers in milliseconds keeps the counters narrow.
	always_comb begin
		ms_tick = (pre_r == PRE_LAST);
		pre_nxt = ms_tick ? '0 : pre_r + PRE_W'(1);
		fl_nxt  = fl_r;
		ph_nxt  = ph_r;
		pt_nxt  = pt_r;
		if (ms_tick) begin
			fl_nxt = (fl_r == FLASH_T) ? '0 : fl_r + TMR_ONE;
			ph_nxt = (fl_r == FLASH_T) ? ph_r + 3'h1 : ph_r;
			pt_nxt = (pt_r == PER_T) ? '0 : pt_r + TMR_ONE;
		end
		flash = ph_r[0];
		irreg = IRREG_PAT[ph_r];
		pulse = (pt_r < PLEN_T);
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pre_r <= '0;
			fl_r  <= '0;
			ph_r  <= '0;
			pt_r  <= '0;
		end else if (en_i) begin
			pre_r <= pre_nxt;
			fl_r  <= fl_nxt;
			ph_r  <= ph_nxt;
			pt_r  <= pt_nxt;
		end
	end

	// Main sequence: self-test, run, test, restart and fault states.
	// Internal faults latch until reset because the unit must be replaced.
	always_comb begin
		st_nxt   = st_r;
		tmr_nxt  = (ms_tick && tmr_r != '1) ? tmr_r + TMR_ONE : tmr_r;
		self_ok  = align_s && conn_s && clear_s && test_s;
		mismatch = (rba_s != safety_switch_output_a_o) ||
			(rbb_s != safety_switch_output_b_o);
		mm_nxt   = mismatch ? ((mm_r == MM_LIM) ? mm_r : mm_r + MM_ONE) : '0;
		if (cerr_s) begin
			st_nxt = ST_CTRL_ERR;
		end else if (ferr_s && st_r != ST_CTRL_ERR) begin
			st_nxt = ST_FIELD_ERR;
		end else if (!supply_s && st_r != ST_CTRL_ERR &&
			st_r != ST_FIELD_ERR) begin
			st_nxt  = ST_LOWPWR;
			tmr_nxt = '0;
		end else if (mm_r == MM_LIM && (st_r == ST_RUN ||
			st_r == ST_TEST || st_r == ST_RESTART)) begin
			st_nxt  = ST_SHORT;
			tmr_nxt = '0;
		end else begin
			case (st_r)
				ST_SELFTEST: begin
					if (!self_ok) begin
						tmr_nxt = '0;
					end else if (ms_tick && tmr_r == START_T) begin
						st_nxt  = ST_RUN;
						tmr_nxt = '0;
					end
				end
				ST_RUN: begin
					if (!test_s) begin
						st_nxt  = ST_TEST;
						tmr_nxt = '0;
					end
				end
				ST_TEST: begin
					// A test shorter than t1 is stretched so it takes effect.
					if (test_s && tmr_r >= T1_T) begin
						st_nxt  = ST_RESTART;
						tmr_nxt = '0;
					end
				end
				ST_RESTART: begin
					if (!test_s) begin
						st_nxt  = ST_TEST;
						tmr_nxt = '0;
					end else if (ms_tick && tmr_r == SETTLE_T) begin
						st_nxt  = ST_RUN;
						tmr_nxt = '0;
					end
				end
				ST_SHORT: begin
					// Leave only after the wiring reads back quiet.
					if (rba_s || rbb_s) begin
						tmr_nxt = '0;
					end else if (ms_tick && tmr_r == SETTLE_T) begin
						st_nxt  = ST_SELFTEST;
						tmr_nxt = '0;
					end
				end
				ST_LOWPWR: begin
					st_nxt  = ST_SELFTEST;
					tmr_nxt = '0;
				end
				ST_CTRL_ERR: st_nxt = ST_CTRL_ERR;
				ST_FIELD_ERR: st_nxt = ST_FIELD_ERR;
				default: st_nxt = ST_SELFTEST;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_r  <= ST_SELFTEST;
			tmr_r <= '0;
			mm_r  <= '0;
		end else if (en_i) begin
			st_r  <= st_nxt;
			tmr_r <= tmr_nxt;
			mm_r  <= mm_nxt;
		end
	end

	// Outputs and indicators, decoded from the next state so that
	// every port is a flip-flop and reacts one cycle after the cause.
	always_comb begin
		run_on  = (st_nxt == ST_RUN) && clear_s && align_s;
		out_nxt = '0;
		out_nxt[0] = run_on;
		out_nxt[1] = run_on;
		out_nxt[2] = test_s && st_nxt != ST_CTRL_ERR &&
			st_nxt != ST_FIELD_ERR;
		out_nxt[3] = (st_nxt == ST_RUN || st_nxt == ST_TEST ||
			st_nxt == ST_RESTART);
		out_nxt[4] = (st_nxt == ST_TEST || st_nxt == ST_RESTART);
		out_nxt[5] = (st_nxt == ST_SHORT);
		// Lamp bits run rx red, green, power, then tx red, green, power.
		case (st_nxt)
			ST_SELFTEST: out_nxt[11:6] = 6'h00;
			ST_LOWPWR: out_nxt[11:6] = 6'h08;
			ST_RUN: out_nxt[11:6] = run_on ?
				{3'b111, !test_s, test_s, 1'b1} :
				{1'b1, 1'b0, flash, !test_s, test_s, 1'b1};
			ST_TEST,
			ST_RESTART: out_nxt[11:6] = {1'b1, 1'b0, flash,
				!test_s, test_s, 1'b1};
			ST_SHORT: out_nxt[11:6] = {flash, 1'b0, pulse,
				!test_s, test_s, 1'b1};
			ST_FIELD_ERR: out_nxt[11:6] = {flash, 1'b0, flash,
				1'b1, 1'b0, flash};
			ST_CTRL_ERR: out_nxt[11:6] = {1'b1, 1'b0, irreg,
				1'b1, 1'b0, flash};
			default: out_nxt[11:6] = 6'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			{rx_led_red_o, rx_led_grn_o, rx_led_pwr_o,
				tx_led_red_o, tx_led_grn_o, tx_led_pwr_o,
				short_fault_o, test_active_o, ready_o, tx_emit_o,
				safety_switch_output_b_o, safety_switch_output_a_o} <= '0;
		end else if (en_i) begin
			{rx_led_red_o, rx_led_grn_o, rx_led_pwr_o,
				tx_led_red_o, tx_led_grn_o, tx_led_pwr_o,
				short_fault_o, test_active_o, ready_o, tx_emit_o,
				safety_switch_output_b_o, safety_switch_output_a_o} <= out_nxt;
		end
	end

	emit_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && !test_s |=> !tx_emit_o && !tx_led_grn_o)
		else $error("emission continued with test contact open");

	test_react_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && st_r == ST_RUN && !test_s && supply_s && !cerr_s && !ferr_s
		&& mm_r != MM_LIM |=> st_r == ST_TEST && test_active_o &&
		!safety_switch_output_a_o && !safety_switch_output_b_o)
		else $error("test opening not taken in one cycle");

	restart_bound_a: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		st_r == ST_RESTART |-> tmr_r <= TMR_W'(RESTART_MAX_MS))
		else $error("restart after test exceeded its limit");

	ready_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(ready_o) |-> $past(st_r) == ST_SELFTEST &&
		$past(tmr_r) == START_T && rx_led_pwr_o)
		else $error("ready raised without completed self-test");

	selftest_hold_a: assert property (@(posedge clk_i)
		disable iff (!nrst_i) en_i && !cerr_s && !ferr_s &&
		st_r == ST_SELFTEST && !self_ok |=> tmr_r == '0 && !ready_o)
		else $error("self-test advanced with bad conditions");

	intrusion_off_a: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		en_i && !clear_s |=> !safety_switch_output_a_o &&
		!safety_switch_output_b_o && !rx_led_grn_o)
		else $error("outputs on with field interrupted");

	short_catch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && mm_r == MM_LIM && st_r == ST_RUN && supply_s && !cerr_s &&
		!ferr_s |=> short_fault_o && !safety_switch_output_a_o)
		else $error("output short not reported");

	led_on_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		safety_switch_output_a_o |-> rx_led_pwr_o && rx_led_grn_o &&
		rx_led_red_o && safety_switch_output_b_o)
		else $error("receiver indicators wrong with outputs on");

	low_supply_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && !supply_s && !cerr_s && !ferr_s && st_r != ST_CTRL_ERR &&
		st_r != ST_FIELD_ERR |=> rx_led_pwr_o && !rx_led_grn_o &&
		!rx_led_red_o)
		else $error("low supply indication wrong");

endmodule

// File: test/relay_model.sv
module relay_model #(
	parameter int unsigned HOLD_CYC = 1
) (
	input  wire logic       clk_i,
	input  wire logic       out_a_i,
	input  wire logic       out_b_i,
	input  wire logic [1:0] short_i,
	input  wire logic       open_req_i,
	output logic            rb_a_o,
	output logic            rb_b_o,
	output logic            test_closed_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned hold_cnt = 0;

	// Sensed wire levels; a short to 0 V (1) or to supply (2) wins.
	assign rb_a_o = (short_i == 2'h1) ? 1'b0 : (short_i == 2'h2) | out_a_i;
	assign rb_b_o = (short_i == 2'h1) ? 1'b0 : (short_i == 2'h2) | out_b_i;

	// A test request opens the contact for HOLD_CYC at least, so a
	// short request cannot undercut the device reaction time.
	always @(posedge clk_i) begin
		if (open_req_i)
			hold_cnt <= HOLD_CYC;
		else if (hold_cnt != 0)
			hold_cnt <= hold_cnt - 1;
	end
	assign test_closed_o = !open_req_i && hold_cnt == 0;
endmodule

// File: test/light_curtain_test_status_logic_bench.sv
module light_curtain_test_status_logic_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import lc_pkg::*;
	localparam int unsigned CPM = 10;
	localparam int unsigned T1C = (RESP_MS_DEF + T1_EXTRA_MS) * CPM;
	logic       clk;
	logic       nrst = 0, fclear = 0, aligned = 1, conn = 1, sup = 1;
	logic       cerr = 0, ferr = 0, open_req = 0, en = 1;
	logic [1:0] short = 2'h0;
	wire logic  rba, rbb, tclosed, oa, ob, emit, rdy, tact, sflt;
	wire logic  tp, tg, tr, rp, rg, rr;
	int         failures = 0, n_compared = 0, cyc = 0;
	integer     seed = 32'hDE0404D8;

	light_curtain_ctrl #(.CYC_PER_MS(CPM), .STARTUP_MS(5), .SETTLE_MS(3))
	light_curtain_ctrl_inst (.clk_i(clk), .nrst_i(nrst), .en_i(en),
		.test_closed_i(tclosed), .field_clear_i(fclear),
		.aligned_i(aligned), .connected_i(conn), .supply_ok_i(sup),
		.ctrl_fault_i(cerr), .field_fault_i(ferr), .readback_a_i(rba),
		.readback_b_i(rbb), .safety_switch_output_a_o(oa),
		.safety_switch_output_b_o(ob), .tx_emit_o(emit), .ready_o(rdy),
		.test_active_o(tact), .short_fault_o(sflt), .tx_led_pwr_o(tp),
		.tx_led_grn_o(tg), .tx_led_red_o(tr), .rx_led_pwr_o(rp),
		.rx_led_grn_o(rg), .rx_led_red_o(rr));

	relay_model #(.HOLD_CYC(T1C + 10)) relay_model_inst (.clk_i(clk),
		.out_a_i(oa), .out_b_i(ob), .short_i(short),
		.open_req_i(open_req), .rb_a_o(rba), .rb_b_o(rbb),
		.test_closed_o(tclosed));

	// Free-running clock at 10 MHz.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Outputs need clear field and sufficient alignment.
	function automatic logic exp_out(input logic c, input logic a);
		return c & a;
	endfunction

	task automatic report_and_stop();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, seen);
		end
	endtask

	// Pins move two sync edges plus one output edge after the drive edge.
	task automatic settle3();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wait_ready(input int lim);
		int i;
		for (i = 0; i < lim && rdy !== 1'b1; i++)
			@(negedge clk);
		chk("ready", rdy, 1'b1);
	endtask

	// Counts red toggles over more than one flash half period.
	task automatic red_flash(input logic exp_flash);
		int   i;
		int   n;
		logic last;
		n = 0;
		last = rr;
		for (i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (rr !== last)
				n++;
			last = rr;
		end
		chk("rx red flashing", n != 0, exp_flash);
	endtask

	task automatic do_reset();
		@(posedge clk) nrst <= 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("out a in reset", oa, 1'b0);
		@(posedge clk) nrst <= 1'b1;
		@(negedge clk);
		chk("rx power in selftest", rp, 1'b0);
		chk("tx power in selftest", tp, 1'b0);
	endtask

	task automatic run_leds();
		chk("rx power", rp, 1'b1);
		chk("rx green", rg, 1'b1);
		chk("rx red", rr, 1'b1);
		chk("tx power", tp, 1'b1);
		chk("tx green", tg, 1'b1);
		chk("tx red", tr, 1'b0);
		chk("emit", emit, 1'b1);
		chk("out b", ob, 1'b1);
	endtask

	// Hang guard, well above the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			report_and_stop();
		end
	end

	initial begin
		int   k;
		int   i;
		logic [31:0] v;
		do_reset();
		repeat (100) @(posedge clk);
		@(negedge clk);
		chk("ready field blocked", rdy, 1'b0);
		@(posedge clk) fclear <= 1'b1;
		conn <= 1'b0;
		repeat (100) @(posedge clk);
		@(negedge clk);
		chk("ready disconnected", rdy, 1'b0);
		@(posedge clk) conn <= 1'b1;
		wait_ready(120);
		run_leds();
		// Intrusion and misalignment, hand case first, then random.
		@(posedge clk) fclear <= 1'b0;
		settle3();
		chk("out a intrusion", oa, 1'b0);
		chk("rx green intrusion", rg, 1'b0);
		chk("rx red intrusion", rr, 1'b1);
		for (k = 0; k < 20; k++) begin
			v = $random(seed);
			@(posedge clk) fclear <= v[0];
			aligned <= v[1] | v[2];
			settle3();
			repeat (v[6:4]) @(negedge clk);
			chk("out a", oa, exp_out(fclear, aligned));
			chk("rx green", rg, exp_out(fclear, aligned));
		end
		@(posedge clk) fclear <= 1'b1;
		aligned <= 1'b1;
		settle3();
		// Test contact opened; the model keeps it open past the limit.
		@(posedge clk) open_req <= 1'b1;
		@(posedge clk) open_req <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("emit in test", emit, 1'b0);
		chk("out a in test", oa, 1'b0);
		chk("test active", tact, 1'b1);
		chk("tx green in test", tg, 1'b0);
		chk("tx red in test", tr, 1'b1);
		for (i = 0; i < 2 * T1C && tclosed !== 1'b1; i++)
			@(negedge clk);
		chk("out a at close", oa, 1'b0);
		for (i = 0; i < RESTART_MAX_MS * CPM && oa !== 1'b1; i++)
			@(negedge clk);
		chk("out a after restart", oa, 1'b1);
		chk("test over", tact, 1'b0);
		// Short to 0 V while on, then to supply while off.
		for (k = 1; k < 3; k++) begin
			@(posedge clk) short <= k[1:0];
			fclear <= (k == 1);
			for (i = 0; i < 40 && sflt !== 1'b1; i++)
				@(negedge clk);
			chk("short flag", sflt, 1'b1);
			chk("out a on short", oa, 1'b0);
			chk("rx green on short", rg, 1'b0);
			red_flash(1'b1);
			@(posedge clk) short <= 2'h0;
			fclear <= 1'b1;
			wait_ready(400);
		end
		@(posedge clk) sup <= 1'b0;
		settle3();
		chk("rx power low", rp, 1'b1);
		chk("rx green low", rg, 1'b0);
		chk("rx red low", rr, 1'b0);
		chk("out a low", oa, 1'b0);
		@(posedge clk) sup <= 1'b1;
		wait_ready(300);
		// Field fault is latched after the pin falls again.
		@(posedge clk) ferr <= 1'b1;
		settle3();
		@(posedge clk) ferr <= 1'b0;
		settle3();
		chk("out a field fault", oa, 1'b0);
		chk("rx green field fault", rg, 1'b0);
		chk("tx green field fault", tg, 1'b0);
		chk("tx red field fault", tr, 1'b1);
		red_flash(1'b1);
		do_reset();
		wait_ready(120);
		// Enable low freezes everything, so a field change waits for it.
		@(posedge clk) en <= 1'b0;
		fclear <= 1'b0;
		settle3();
		chk("out a frozen", oa, 1'b1);
		@(posedge clk) en <= 1'b1;
		settle3();
		chk("out a thawed", oa, 1'b0);
		@(posedge clk) fclear <= 1'b1;
		@(posedge clk) cerr <= 1'b1;
		settle3();
		chk("out a ctrl fault", oa, 1'b0);
		chk("rx green ctrl fault", rg, 1'b0);
		chk("tx red ctrl fault", tr, 1'b1);
		red_flash(1'b0);
		report_and_stop();
	end
endmodule
